/* File: bmd_mapper.sv */
`timescale 1ns/1ps
module bmd_mapper
	import bmd_pkg::*;
#(
	parameter int NMI_CYC = NMI_PULSE_CYC
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [15:0] cpuAddr,
	input wire logic [7:0] cpuDataIn,
	output logic [7:0] cpuDataOut,
	output logic cpuDataOe,
	input wire logic memoryRequest_n,
	input wire logic firstCycle_n,
	input wire logic readStrobe_n,
	input wire logic ioRequest_n,
	input wire logic cardSense_n,
	input wire logic powerDown,
	input wire logic romProgramming,
	input wire logic [7:0] memData,
	output logic [MEM_ADDR_W-1:0] memAddr,
	output logic physicalAddrTop,
	output logic memWrite,
	output logic internalRomEnable_n,
	output logic internalRamEnable_n,
	output logic card1Enable_n,
	output logic card2Enable_n,
	output logic card3Enable_n,
	output logic romOutputEnable_n,
	output logic ramOutputEnable_n,
	output logic nmiRequest_n
);
	// The pulse assertions look eight cycles ahead, so shorter pulses are refused
	if (NMI_CYC < 8 || NMI_CYC > 65535)
	begin : gNmiCycCheck
		$error("NMI_CYC out of range");
	end

	bmd_pins_t pinRaw;
	bmd_pins_t s1_q;
	bmd_pins_t s2_q;
	bmd_pins_t s3_q;
	bmd_pins_t pin_q;
	bmd_pins_t pin_d;

	// All processor and card pins arrive unrelated to clk
	assign pinRaw = '{cpuAddr, cpuDataIn, memData, memoryRequest_n, firstCycle_n,
		readStrobe_n, ioRequest_n, cardSense_n, powerDown, romProgramming};

	// Three-stage synchroniser; a bit moves only once stages two and three agree
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q <= PINS_IDLE;
			s2_q <= PINS_IDLE;
			s3_q <= PINS_IDLE;
			pin_q <= PINS_IDLE;
		end
		else
		begin
			s1_q <= pinRaw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end

	// Bitwise majority of agree-or-hold
	assign pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));

	// Bus cycle classification from the filtered strobes
	logic memActive;
	logic readCyc;
	logic fetchCyc;
	logic refreshCyc;
	logic writeCyc;
	logic selfRefresh;
	logic accessValid;
	logic mreqPrev_q;
	logic mreqRise;
	logic curFetch_q;
	logic lastFetch_q;
	logic writePrev_q;

	assign memActive = !pin_q.mreqN;
	assign readCyc = memActive && !pin_q.rdN; // R10
	assign fetchCyc = readCyc && !pin_q.m1N;
	// A strobe with read idle right after a fetch is the processor's refresh
	assign refreshCyc = memActive && pin_q.rdN && pin_q.m1N && lastFetch_q; // R17
	assign writeCyc = memActive && pin_q.rdN && pin_q.m1N && !lastFetch_q; // R11
	assign selfRefresh = pin_q.powerDown || pin_q.programming; // R16
	assign accessValid = (readCyc || writeCyc) && !selfRefresh; // R19
	assign mreqRise = mreqPrev_q && !memActive;

	// Remember whether the memory cycle just ended was an opcode fetch
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mreqPrev_q <= 1'b0;
			curFetch_q <= 1'b0;
			lastFetch_q <= 1'b0;
			writePrev_q <= 1'b0;
		end
		else
		begin
			mreqPrev_q <= memActive;
			writePrev_q <= writeCyc;
			if (mreqRise)
			begin
				lastFetch_q <= curFetch_q; // R17
				curFetch_q <= 1'b0;
			end
			else if (fetchCyc)
				curFetch_q <= 1'b1;
		end
	end

	// Bank register path
	bmd_bank_if bankBus ();
	bmd_bank_t bankSel;
	logic ioWrite;
	logic ioWritePrev_q;

	bmd_bank_regs uRegs (
		.clk(clk),
		.arst_n(arst_n),
		.bus(bankBus)
	);

	// I/O write: request low, read idle, not an interrupt acknowledge
	assign ioWrite = !pin_q.iorqN && pin_q.rdN && pin_q.m1N
		&& pin_q.addr[BANK_PORT_SEL_BIT] && pin_q.addr[7:4] == BANK_PORT_HI; // R09
	assign bankBus.we = ioWrite && !ioWritePrev_q;
	assign bankBus.wIdx = pin_q.addr[1:0];
	assign bankBus.wData = pin_q.data;
	assign bankBus.rIdx = pin_q.addr[15:14]; // R05
	assign bankSel = bmd_bank_t'(bankBus.rData); // R02

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ioWritePrev_q <= 1'b0;
		else
			ioWritePrev_q <= ioWrite;
	end

	// Chip selection; the decode is one-hot by construction
	logic [SEL_W-1:0] selNow;
	logic [SEL_W-1:0] en_q;
	logic [SEL_W-1:0] en_d;
	logic romRead;

	assign selNow = bmdDecode(bankSel); // R04 R06
	assign en_d = accessValid ? selNow : '0; // R19
	assign romRead = readCyc && !selfRefresh && selNow[SEL_ROM];

	// Enables and address are registered so no decode glitch reaches a chip
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			en_q <= '0;
			memAddr <= '0;
			physicalAddrTop <= 1'b0;
		end
		else
		begin
			en_q <= en_d;
			{physicalAddrTop, memAddr} <= {bankSel.page, pin_q.addr[OFFSET_W-1:0]}; // R03 R12 R15
		end
	end

	assign internalRomEnable_n = !en_q[SEL_ROM]; // R07
	assign internalRamEnable_n = !en_q[SEL_RAM]; // R08
	assign card1Enable_n = !en_q[SEL_CARD_BASE + 1]; // R14
	assign card2Enable_n = !en_q[SEL_CARD_BASE + 2]; // R14
	assign card3Enable_n = !en_q[SEL_CARD_BASE + 3]; // R14

	// Output enables and write direction
	logic romOe_d;
	logic ramOe_d;
	logic anyRam;
	logic romOe_q;
	logic ramOe_q;

	assign anyRam = |selNow[SEL_W-1:SEL_RAM];
	assign romOe_d = romRead; // R10
	// Self refresh forces the shared enable/refresh line low
	assign ramOe_d = selfRefresh || (readCyc && anyRam); // R10 R16

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			romOe_q <= 1'b0;
			ramOe_q <= 1'b0;
			memWrite <= 1'b1;
		end
		else
		begin
			romOe_q <= romOe_d;
			ramOe_q <= ramOe_d;
			// Two agreeing cycles hide the skew between strobe edges
			memWrite <= !(writeCyc && writePrev_q && !selfRefresh); // R11
		end
	end

	assign romOutputEnable_n = !romOe_q;
	assign ramOutputEnable_n = !ramOe_q;

	// EPROM data is passed through to the processor only during its reads
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cpuDataOut <= 8'h00;
			cpuDataOe <= 1'b0;
		end
		else
		begin
			cpuDataOut <= pin_q.memData; // R13
			cpuDataOe <= romRead; // R13
		end
	end

	// Card sense watch; a falling edge starts a fixed-length interrupt pulse
	logic sensePrev_q;
	logic senseFall;
	logic [15:0] nmiCnt_q;

	assign senseFall = sensePrev_q && !pin_q.senseN; // R18

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sensePrev_q <= 1'b1;
			nmiCnt_q <= '0;
		end
		else
		begin
			sensePrev_q <= pin_q.senseN;
			if (senseFall)
				nmiCnt_q <= 16'(NMI_CYC); // R18
			else if (nmiCnt_q != 16'h0000)
				nmiCnt_q <= nmiCnt_q - 16'h0001;
		end
	end

	assign nmiRequest_n = nmiCnt_q == 16'h0000;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	logic [SEL_W-1:0] enOut;
	assign enOut = {!card3Enable_n, !card2Enable_n, !card1Enable_n, !internalRamEnable_n,
		!internalRomEnable_n};

	// Chip enables: never two at once, none outside a decoded access
	AST_ONE_ENABLE: assert property ($onehot0(enOut)) // R19
		else $error("more than one chip enable active");

	AST_IDLE_NO_ENABLE: assert property (!accessValid |=> enOut == '0) // R19
		else $error("chip enable outside a valid memory cycle");

	AST_ROM_SELECT: assert property (accessValid && bankSel.seg == SEG_INTERNAL // R07
		&& !bankSel.page[PAGE_HALF_BIT] |=> !internalRomEnable_n)
		else $error("EPROM enable missing");

	AST_RAM_SELECT: assert property (accessValid && bankSel.seg == SEG_INTERNAL // R08
		&& bankSel.page[PAGE_HALF_BIT] |=> !internalRamEnable_n && internalRomEnable_n)
		else $error("internal RAM enable missing");

	AST_CARD_SELECT: assert property (accessValid && bankSel.seg != SEG_INTERNAL // R14
		|=> $countones(enOut[SEL_W-1:SEL_CARD_BASE+1]) == 1 && internalRamEnable_n)
		else $error("card slot enable wrong");

	// Address lines: offset from the processor, page and top line from the bank
	AST_ADDR_FORM: assert property (1'b1 |=> // R03
		memAddr[OFFSET_W-1:0] == $past(pin_q.addr[OFFSET_W-1:0])
		&& {physicalAddrTop, memAddr[MEM_ADDR_W-1:OFFSET_W]} == $past(bankSel.page))
		else $error("physical address not formed from page and offset");

	AST_PAGE_FIELD: assert property (1'b1 |=> // R02
		{physicalAddrTop, memAddr[MEM_ADDR_W-1:OFFSET_W]} == $past(bankBus.rData[PAGE_W-1:0]))
		else $error("page number not taken from the low bank bits");

	// Refresh: self refresh levels, and no access for the refresh address
	AST_SELF_REFRESH: assert property (selfRefresh [*2] |-> !ramOutputEnable_n // R16
		&& internalRamEnable_n && card1Enable_n && card2Enable_n && card3Enable_n)
		else $error("self refresh levels wrong");

	AST_REFRESH_IGNORED: assert property (refreshCyc |=> enOut == '0) // R17
		else $error("memory access started for refresh address");

	// Strobes: write direction and output enables
	AST_WRITE_DIR: assert property (readCyc |=> memWrite) // R11
		else $error("write output low during a read");

	AST_WRITE_LOW: assert property ((writeCyc && !selfRefresh) [*2] |=> !memWrite) // R11
		else $error("write output high during a write");

	AST_ROM_OE: assert property (romRead |=> !romOutputEnable_n) // R10
		else $error("EPROM output enable missing during a read");

	AST_OE_IDLE: assert property (!readCyc && !selfRefresh |=> romOutputEnable_n // R10
		&& ramOutputEnable_n)
		else $error("output enable active outside a read");

	AST_RAM_OE: assert property (readCyc && anyRam |=> !ramOutputEnable_n) // R10
		else $error("RAM output enable missing during a read");

	// Data path and bank writes; the edge detect keeps one write per I/O cycle
	AST_ROM_DATA: assert property (romRead |=> cpuDataOe // R13
		&& cpuDataOut == $past(pin_q.memData))
		else $error("EPROM data not passed to processor");

	AST_DATA_GATE: assert property (!romRead |=> !cpuDataOe) // R13
		else $error("processor data driven outside an EPROM read");

	AST_BANK_ONE_WRITE: assert property (bankBus.we |=> !bankBus.we) // R09
		else $error("bank register written twice in one I/O cycle");

	// Interrupt pulse: starts on a sense fall, ends on time, never on its own
	AST_NMI_PULSE: assert property (senseFall |=> !nmiRequest_n [*8]) // R18
		else $error("card sense did not raise interrupt");

	AST_NMI_QUIET: assert property (nmiCnt_q == 16'h0001 && !senseFall |=> nmiRequest_n) // R18
		else $error("interrupt pulse too long");

	AST_NMI_CAUSE: assert property (nmiRequest_n && !senseFall |=> nmiRequest_n) // R18
		else $error("interrupt raised without a card sense fall");

	// Main scenarios reached
	COV_ROM_READ: cover property (romRead ##1 !romOutputEnable_n);
	COV_SELF_REFRESH: cover property (selfRefresh [*2] ##1 !ramOutputEnable_n);
	COV_CARD_WRITE: cover property (writeCyc && bankSel.seg != SEG_INTERNAL ##2 !memWrite);
	COV_FETCH_REFRESH: cover property (fetchCyc ##[1:20] refreshCyc);
	COV_CARD_SENSE: cover property (senseFall);
endmodule

/* File: bmd_pkg.sv */
// Operation
// R01: Four bank registers widen the 16-bit logical address to 22 physical bits.
// R02: Low six bits of each 8-bit bank register give a 16k page, 0 to 63.
// R03: Physical address joins the page number with logical offset bits A13..A0.
// R04: Top two register bits pick segment: 0 internal, 1 to 3 card slots.
// R05: Logical address bits A15 and A14 choose the bank register used.
// R06: In segment 0, register bit A19 picks internal EPROM or internal RAM.
// R07: Register bits A21..A19 all zero assert the active-low EPROM chip enable.
// R08: A21, A20 zero and A19 one assert the active-low internal RAM enable.
// R09: The processor loads a bank register by I/O write with A3 high.
// R10: Memory output enables come from first-cycle, read strobe and memory request; the code uses only read strobe and memory request, not first-cycle.
// R11: Write output is high for memory reads and low for memory writes.
// R12: Memory address lines carry A13..A0 with the five low bank bits above.
// R13: Internal EPROM read data is gated onto the processor data bus.
// R14: Card accesses decode the segment into one of three slot enables.
// R15: Upper memory address lines 16 to 19 reach every card slot.
// R16: Power-down or programming holds RAM enables high and RAM output enable low.
// R17: The refresh cycle after an opcode fetch starts no memory access.
// R18: A card sense line pulled low raises the non-maskable interrupt.
// R19: At most one chip enable, and none outside valid memory cycles.
package bmd_pkg;
	localparam int BANK_W = 8;
	localparam int BANK_N = 4;
	localparam int PAGE_W = 6;
	localparam int PAGE_HALF_BIT = 5;
	localparam int OFFSET_W = 14;
	localparam int MEM_ADDR_W = 19;
	// Bank registers answer I/O writes whose address high nibble is this
	localparam logic [3:0] BANK_PORT_HI = 4'hd;
	localparam int BANK_PORT_SEL_BIT = 3;
	localparam logic [BANK_W-1:0] BANK_RESET = 8'h00;
	localparam logic [1:0] SEG_INTERNAL = 2'h0;
	// One-hot chip select positions; card s sits at SEL_CARD_BASE + s
	localparam int SEL_W = 5;
	localparam int SEL_ROM = 0;
	localparam int SEL_RAM = 1;
	localparam int SEL_CARD_BASE = 1;
	localparam int CLK_PERIOD_NS = 20;
	localparam int NMI_PULSE_NS = 1000;
	localparam int NMI_PULSE_CYC = (NMI_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic [1:0] seg;
		logic [PAGE_W-1:0] page;
	} bmd_bank_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
		logic [7:0] memData;
		logic mreqN;
		logic m1N;
		logic rdN;
		logic iorqN;
		logic senseN;
		logic powerDown;
		logic programming;
	} bmd_pins_t;

	localparam bmd_pins_t PINS_IDLE = '{16'h0000, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
		1'b0, 1'b0};

	// One-hot selection of the device addressed by a bank register
	function automatic logic [SEL_W-1:0] bmdDecode(input bmd_bank_t b);
		logic [SEL_W-1:0] sel;
		sel = '0;
		if (b.seg == SEG_INTERNAL)
			sel[b.page[PAGE_HALF_BIT] ? SEL_RAM : SEL_ROM] = 1'b1;
		else
			sel[SEL_CARD_BASE + int'(b.seg)] = 1'b1;
		return sel;
	endfunction
endpackage

/* File: bmd_bank_if.sv */
`timescale 1ns/1ps
// Write and read path between the cycle decoder and the bank store
interface bmd_bank_if;
	logic we;
	logic [1:0] wIdx;
	logic [7:0] wData;
	logic [1:0] rIdx;
	logic [7:0] rData;
	modport ctrl (output we, output wIdx, output wData, output rIdx, input rData);
	modport store (input we, input wIdx, input wData, input rIdx, output rData);
endinterface

/* File: bmd_bank_regs.sv */
`timescale 1ns/1ps
module bmd_bank_regs
	import bmd_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	bmd_bank_if.store bus
);
	logic [BANK_W-1:0] bank_q [BANK_N];

	// One flop group per bank register
	genvar g;
	generate
		for (g = 0; g < BANK_N; g++)
		begin : gBank
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					bank_q[g] <= BANK_RESET;
				else if (bus.we && bus.wIdx == 2'(g))
					bank_q[g] <= bus.wData; // R09
			end
		end
	endgenerate

	// Selected register, indexed by the logical address top bits
	assign bus.rData = bank_q[bus.rIdx]; // R01

	AST_BANK_LOAD: assert property (@(posedge clk) disable iff (!arst_n) // R09
		bus.we |=> bank_q[$past(bus.wIdx)] == $past(bus.wData))
		else $error("bank register did not take written value");
endmodule

/* File: bmd_mem_model.sv */
`timescale 1ns/1ps
// Memory devices behind the mapper: EPROM and internal RAM share one data bus
module bmd_mem_model (
	input wire logic clk,
	input wire logic [18:0] memAddr,
	input wire logic romEnable_n,
	input wire logic romOe_n,
	input wire logic ramEnable_n,
	input wire logic ramOe_n,
	output logic [7:0] memData
);
	logic [7:0] lastQ = 8'h00;
	logic drive;
	// A device drives only with both its enables low; a released bus toggles
	// so a stale value can never pass for fresh data
	assign drive = (!romEnable_n && !romOe_n) || (!ramEnable_n && !ramOe_n);
	assign memData = drive ? (memAddr[7:0] ^ memAddr[18:11]) : ~lastQ;
	// Last bus value, kept only to invert it while released
	always_ff @(posedge clk)
		lastQ <= memData;
endmodule

/* File: bmd_mapper_test.sv */
`timescale 1ns/1ps
module bmd_mapper_test import bmd_pkg::*;;
	localparam int NMI_T = 10;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] cpuAddr = 16'h0000;
	logic [7:0] cpuDataIn = 8'h00;
	logic memoryRequest_n = 1'b1;
	logic firstCycle_n = 1'b1;
	logic readStrobe_n = 1'b1;
	logic ioRequest_n = 1'b1;
	logic cardSense_n = 1'b1;
	logic powerDown = 1'b0;
	logic romProgramming = 1'b0;
	logic [7:0] memData;
	logic [7:0] cpuDataOut;
	logic cpuDataOe;
	logic [MEM_ADDR_W-1:0] memAddr;
	logic physicalAddrTop, memWrite, romEn_n, ramEn_n, c1En_n, c2En_n, c3En_n;
	logic romOe_n, ramOe_n, nmiRequest_n;
	logic [7:0] bank [4];
	logic [31:0] lfsr = 32'hba24;
	logic [7:0] cor [8] = '{8'h00, 8'h20, 8'h5f, 8'hff, 8'h40, 8'h80, 8'hc0, 8'h1f};
	int errTotal = 0;
	int testsRun = 0;
	int k;
	// Clock at 50 MHz
	always #10 clk = ~clk;
	bmd_mapper #(.NMI_CYC(NMI_T)) dut (.clk(clk), .arst_n(arst_n), .cpuAddr(cpuAddr),
		.cpuDataIn(cpuDataIn), .cpuDataOut(cpuDataOut), .cpuDataOe(cpuDataOe),
		.memoryRequest_n(memoryRequest_n), .firstCycle_n(firstCycle_n),
		.readStrobe_n(readStrobe_n), .ioRequest_n(ioRequest_n), .cardSense_n(cardSense_n),
		.powerDown(powerDown), .romProgramming(romProgramming), .memData(memData),
		.memAddr(memAddr), .physicalAddrTop(physicalAddrTop), .memWrite(memWrite),
		.internalRomEnable_n(romEn_n), .internalRamEnable_n(ramEn_n),
		.card1Enable_n(c1En_n), .card2Enable_n(c2En_n), .card3Enable_n(c3En_n),
		.romOutputEnable_n(romOe_n), .ramOutputEnable_n(ramOe_n), .nmiRequest_n(nmiRequest_n));
	bmd_mem_model mem (.clk(clk), .memAddr(memAddr), .romEnable_n(romEn_n), .romOe_n(romOe_n),
		.ramEnable_n(ramEn_n), .ramOe_n(ramOe_n), .memData(memData));
	// Shift register for repeatable random stimulus
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected selects, active high: {card3, card2, card1, ram, rom}
	function automatic logic [4:0] expEn(input logic [7:0] b);
		if (b[7:6] == 2'd0)
			return b[5] ? 5'b00010 : 5'b00001;
		return 5'b00001 << (3'(b[7:6]) + 3'd1); // Three bits so slot 3 reaches bit 4
	endfunction
	function automatic logic [4:0] seenEn();
		return ~{c3En_n, c2En_n, c1En_n, ramEn_n, romEn_n};
	endfunction
	task automatic wrapUp();
		if (errTotal == 0 && testsRun > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Settle past the edge so registered outputs are read after they land
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp)
		begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Pins change just after a rising edge and then hold
	task automatic pins(input logic [15:0] a, input logic mr, m1, rd, io);
		@(posedge clk);
		cpuAddr <= a;
		memoryRequest_n <= mr;
		firstCycle_n <= m1;
		readStrobe_n <= rd;
		ioRequest_n <= io;
	endtask
	task automatic ioWrite(input logic [7:0] port, input logic [7:0] d);
		@(posedge clk);
		cpuDataIn <= d;
		pins({8'h00, port}, 1'b1, 1'b1, 1'b1, 1'b0);
		step(5);
		pins(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1);
		step(5);
		if (port[7:3] == 5'b11011)
			bank[port[1:0]] = d;
	endtask
	task automatic rdChk(input logic [1:0] idx, input logic [13:0] off);
		logic [4:0] e;
		e = expEn(bank[idx]);
		pins({idx, off}, 1'b0, 1'b1, 1'b0, 1'b1);
		step(10);
		chk("enables", {27'd0, e}, {27'd0, seenEn()});
		chk("memAddr", {13'd0, bank[idx][4:0], off}, {13'd0, memAddr});
		chk("addrTop", {31'd0, bank[idx][5]}, {31'd0, physicalAddrTop});
		chk("romOe", {31'd0, ~e[0]}, {31'd0, romOe_n});
		chk("memWrite", 32'd1, {31'd0, memWrite});
		chk("ramOe", {31'd0, ~|e[4:1]}, {31'd0, ramOe_n});
		chk("cpuDataOe", {31'd0, e[0]}, {31'd0, cpuDataOe});
		if (e[0])
			chk("cpuData", {24'd0, off[7:0] ^ {bank[idx][4:0], off[13:11]}},
				{24'd0, cpuDataOut});
		pins(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1);
		step(6);
		chk("idleEnables", 32'd0, {27'd0, seenEn()});
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		step(1);
		// Corner banks: each fourth write, read back all four windows
		for (int i = 0; i < 8; i++)
		begin
			ioWrite({5'b11011, 1'b0, i[1:0]}, cor[i]);
			if (i[1:0] == 2'd3)
				for (int j = 0; j < 4; j++)
					rdChk(j[1:0], j[0] ? 14'h3fff : 14'h0000);
		end
		// A write with bit 3 low must leave the bank unchanged
		ioWrite(8'hd0, 8'h33);
		rdChk(2'd0, 14'h1234);
		for (int i = 0; i < 12; i++)
		begin
			lfsr = nextRand(lfsr);
			ioWrite({5'b11011, 1'b0, lfsr[1:0]}, lfsr[15:8]);
			rdChk(lfsr[1:0], lfsr[29:16]);
		end
		// Memory write: memWrite low with the chip enable
		pins(16'h4321, 1'b0, 1'b1, 1'b1, 1'b1);
		step(10);
		chk("wrMemWrite", 32'd0, {31'd0, memWrite});
		chk("wrEnables", {27'd0, expEn(bank[1])}, {27'd0, seenEn()});
		// Opcode fetch then refresh: the refresh address starts no access
		pins(16'h0100, 1'b0, 1'b0, 1'b0, 1'b1);
		step(5);
		pins(16'h0100, 1'b1, 1'b1, 1'b1, 1'b1);
		// The pin filter swallows a one-cycle gap, so the request stays high longer
		step(3);
		pins(16'h0055, 1'b0, 1'b1, 1'b1, 1'b1);
		step(8);
		chk("rfshEnables", 32'd0, {27'd0, seenEn()});
		chk("rfshMemWrite", 32'd1, {31'd0, memWrite});
		pins(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1);
		step(6);
		// Power-down and programming put the RAMs into self-refresh
		ioWrite(8'hd8, 8'h20);
		for (int i = 0; i < 2; i++)
		begin
			pins(16'h0010, 1'b0, 1'b1, 1'b0, 1'b1);
			powerDown <= (i == 0);
			romProgramming <= (i == 1);
			step(10);
			chk("pdEnables", 32'd0, {27'd0, seenEn()});
			chk("pdRamOe", 32'd0, {31'd0, ramOe_n});
			chk("pdMemWrite", 32'd1, {31'd0, memWrite});
			pins(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1);
			powerDown <= 1'b0;
			romProgramming <= 1'b0;
			step(6);
		end
		// Card sense falls: one interrupt pulse of the set length
		@(posedge clk);
		cardSense_n <= 1'b0;
		for (k = 0; k < 10 && nmiRequest_n !== 1'b0; k++)
			step(1);
		chk("nmiSeen", 32'd0, {31'd0, nmiRequest_n});
		for (k = 0; k < 40 && nmiRequest_n === 1'b0; k++)
			step(1);
		chk("nmiLength", NMI_T, k);
		@(posedge clk);
		cardSense_n <= 1'b1;
		step(4);
		// Reset in mid-run: outputs fall back and the banks clear
		@(posedge clk);
		arst_n <= 1'b0;
		step(2);
		chk("rstEnables", 32'd0, {27'd0, seenEn()});
		chk("rstMemWrite", 32'd1, {31'd0, memWrite});
		chk("rstNmi", 32'd1, {31'd0, nmiRequest_n});
		chk("rstDataOe", 32'd0, {31'd0, cpuDataOe});
		chk("rstMemAddr", 32'd0, {13'd0, memAddr});
		@(posedge clk);
		arst_n <= 1'b1;
		for (int j = 0; j < 4; j++)
			bank[j] = BANK_RESET;
		step(1);
		rdChk(2'd3, 14'h2aaa);
		wrapUp();
	end
endmodule
